// ===== supervisor_pkg.sv
// Constants and types shared by the reset gate and panel-loss supervisor
`default_nettype none

package supervisor_pkg;

  // ==========================================================
  // Register map
  localparam logic [3:0] SEL_OFFSET = 4'h0;
  localparam logic [3:0] STATUS_OFFSET = 4'h4;
  localparam logic [6:0] SEL_RESET = 7'h0E;
  localparam int ST_FAULT = 0;
  localparam int ST_PANEL_LOSS = 1;
  localparam int ST_BLOCKED = 2;
  localparam int ST_ARMED = 3;
  localparam int ST_TRIPS = 4;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 40000000;
  localparam int PANEL_LOSS_MS = 1000;
  localparam int PANEL_LOSS_CYCLES = CLK_HZ / 1000 * PANEL_LOSS_MS;
  localparam logic [1:0] LIMIT_TRIPS = 2'h2;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    MODE_PANEL = 2'h0,
    MODE_EXTERNAL = 2'h1,
    MODE_NETWORK = 2'h2
  } opMode_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wrData;
    logic wr;
    logic rd;
  } busReq_t;

  typedef struct packed {
    logic onlyOnTrip;
    logic panelTrip;
    logic stopAll;
    logic continueCode;
    logic limitOn;
  } selDecode_t;

  // Codes fold onto a base of 0..3 or 14..17; the low two bits of the offset within each group carry the options
  function automatic selDecode_t decodeSel(input logic [6:0] code);
    logic [6:0] base;
    selDecode_t d;
    base = (code >= 7'h64) ? 7'(code - 7'h64) : code;
    d.onlyOnTrip = base[0];
    d.panelTrip = (base >= 7'h0E) ? base[1] ^ base[0] ^ base[0] ^ (base == 7'h10 || base == 7'h11)
                                  ^ base[1] : base[1];
    d.stopAll = (base >= 7'h0E);
    d.continueCode = (code == 7'h00 || code == 7'h01 || code == 7'h0E || code == 7'h0F);
    d.limitOn = (code >= 7'h64);
    return d;
  endfunction : decodeSel

  function automatic logic selLegal(input logic [31:0] v, input logic highCap);
    logic [6:0] base;
    logic ok;
    base = (v[6:0] >= 7'h64) ? 7'(v[6:0] - 7'h64) : v[6:0];
    ok = (base <= 7'h03) || (base >= 7'h0E && base <= 7'h11);
    if (v[6:0] >= 7'h64 && !highCap) begin
      ok = 1'b0;
    end
    if (v[31:7] != 25'h0 || (v[6:0] > 7'h03 && v[6:0] < 7'h0E)) begin
      ok = ok && 1'b0;
    end
    return ok && (v[6:0] < 7'h12 || v[6:0] >= 7'h64);
  endfunction : selLegal

endpackage : supervisor_pkg

`default_nettype wire

// ===== panel_loss_timer.sv
// Continuous panel-absence timer with power-on arming
`default_nettype none

module panel_loss_timer #(
  parameter int LossCycles = supervisor_pkg::PANEL_LOSS_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic present,
  output logic lost,
  output logic armed
);
  import supervisor_pkg::*;

  typedef enum logic [3:0] {
    UNARMED = 4'h1,
    PRESENT = 4'h2,
    ABSENT = 4'h4,
    LOST = 4'h8
  } lossState_t;

  typedef struct packed {
    lossState_t st;
    logic [31:0] cnt;
  } timerState_t;

  timerState_t s_q, s_d;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (ce) begin
      case (s_q.st)
        UNARMED: begin
          if (present) begin
            s_d.st = PRESENT;
          end
        end
        PRESENT: begin
          if (!present) begin
            s_d.st = ABSENT;
            s_d.cnt = 32'h1;
          end
        end
        ABSENT: begin
          if (present) begin
            s_d.st = PRESENT;
            s_d.cnt = 32'h0;
          end else if (s_q.cnt >= 32'(LossCycles)) begin
            s_d.st = LOST;
          end else begin
            s_d.cnt = s_q.cnt + 32'h1;
          end
        end
        LOST: begin
          if (present) begin
            s_d.st = PRESENT;
            s_d.cnt = 32'h0;
          end
        end
        default: begin
          s_d.st = UNARMED;
          s_d.cnt = 32'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{st: UNARMED, cnt: 32'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign lost = (s_q.st == LOST);
  assign armed = (s_q.st != UNARMED);

  // ==========================================================
  // Checks
  property p_restart;
    @(posedge clk) disable iff (!resetn)
      (ce && s_q.st == ABSENT && present) |=> (s_q.cnt == 32'h0 && s_q.st == PRESENT);
  endproperty
  a_restart: assert property (p_restart) else $error("absence timer did not restart");

  property p_unarmed;
    @(posedge clk) disable iff (!resetn)
      (s_q.st == UNARMED && !present) |=> !lost;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("loss flagged before arming");

endmodule : panel_loss_timer

`default_nettype wire

// ===== reset_limit.sv
// Consecutive thermal/overcurrent trip counter that blocks resets
`default_nettype none

module reset_limit (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic enable,
  input wire logic thermTrip,
  input wire logic thermalZero,
  output logic blocked,
  output logic [1:0] trips,
  output logic porClear
);
  import supervisor_pkg::*;

  typedef struct packed {
    logic [1:0] trips;
    logic porPending;
  } limitState_t;

  limitState_t s_q, s_d;

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.porPending = 1'b0;
      if (thermTrip && s_q.trips < LIMIT_TRIPS) begin
        s_d.trips = s_q.trips + 2'h1;
      end else if (thermalZero && !thermTrip) begin
        s_d.trips = 2'h0;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{trips: 2'h0, porPending: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  assign blocked = enable && (s_q.trips >= LIMIT_TRIPS) && !thermalZero;
  assign trips = s_q.trips;
  assign porClear = s_q.porPending;

  // ==========================================================
  // Checks
  property p_block;
    @(posedge clk) disable iff (!resetn)
      (enable && s_q.trips == 2'h1 && thermTrip && ce) ##1 (!thermalZero) |-> blocked;
  endproperty
  a_block: assert property (p_block) else $error("second trip did not block resets");

endmodule : reset_limit

`default_nettype wire

// ===== reset_panel_supervisor.sv
// Reset acceptance gate, panel-loss supervisor and stop-key selector
`default_nettype none

module reset_panel_supervisor #(
  parameter int LossCycles = supervisor_pkg::PANEL_LOSS_CYCLES,
  parameter logic HighCapacity = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire supervisor_pkg::busReq_t bus,
  output logic [31:0] rdData,
  input wire logic tripActive,
  input wire logic thermOcTrip,
  input wire logic thermalZero,
  input wire logic running,
  input wire supervisor_pkg::opMode_t opMode,
  input wire logic panelPresent,
  input wire logic serialOnConnector,
  input wire logic panelJog,
  input wire logic extResetTerminal,
  input wire logic commResetCmd,
  input wire logic panelResetKey,
  input wire logic panelStopKey,
  input wire logic paramClear,
  output logic resetAccepted,
  output logic outputShutoff,
  output logic thermalClear,
  output logic panelLossFault,
  output logic decelStop
);
  import supervisor_pkg::*;

  typedef struct packed {
    logic [6:0] sel;
    logic panelFault;
    logic resetAccepted;
    logic outputShutoff;
    logic thermalClear;
    logic decelStop;
    logic [31:0] rdData;
  } supState_t;

  supState_t s_q, s_d;
  selDecode_t dec;
  logic lost;
  logic armed;
  logic blocked;
  logic [1:0] trips;
  logic porClear;
  logic faultActive;
  logic extReq;
  logic acceptNow;
  logic lossTrip;
  logic jogStop;
  logic keyStop;
  logic selWrite;
  logic selOk;

  // ==========================================================
  // Submodules
  panel_loss_timer #(
    .LossCycles(LossCycles)
  ) lossTimer (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .present(panelPresent),
    .lost(lost),
    .armed(armed)
  );

  reset_limit limiter (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .enable(dec.limitOn),
    .thermTrip(thermOcTrip),
    .thermalZero(thermalZero),
    .blocked(blocked),
    .trips(trips),
    .porClear(porClear)
  );

  // ==========================================================
  // Decisions
  always_comb begin
    dec = decodeSel(s_q.sel);
    faultActive = tripActive || s_q.panelFault;
    extReq = extResetTerminal || commResetCmd;
    acceptNow = !blocked
      && ((extReq && (!dec.onlyOnTrip || faultActive))
      || (panelResetKey && faultActive));
    // Serial use of the connector means no panel to lose
    lossTrip = lost && dec.panelTrip && !serialOnConnector;
    jogStop = panelJog && lost && dec.continueCode && !serialOnConnector;
    keyStop = panelStopKey && (opMode == MODE_PANEL || dec.stopAll);
    selWrite = bus.wr && bus.addr == SEL_OFFSET;
    selOk = selLegal(bus.wrData, HighCapacity);
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    if (ce) begin
      // Write protection and run state are deliberately not consulted
      if (selWrite && selOk) begin
        s_d.sel = bus.wrData[6:0];
      end
      // A new loss wins over a reset in the same cycle
      if (lossTrip) begin
        s_d.panelFault = 1'b1;
      end else if (acceptNow) begin
        s_d.panelFault = 1'b0;
      end
      s_d.resetAccepted = acceptNow;
      s_d.outputShutoff = acceptNow && running;
      s_d.thermalClear = acceptNow || porClear;
      s_d.decelStop = jogStop || keyStop;
      s_d.rdData = 32'h0;
      if (bus.rd) begin
        case (bus.addr)
          SEL_OFFSET: begin
            s_d.rdData = {25'h0, s_q.sel};
          end
          STATUS_OFFSET: begin
            s_d.rdData[ST_FAULT] = faultActive;
            s_d.rdData[ST_PANEL_LOSS] = s_q.panelFault;
            s_d.rdData[ST_BLOCKED] = blocked;
            s_d.rdData[ST_ARMED] = armed;
            s_d.rdData[ST_TRIPS +: 2] = trips;
          end
          default: begin
            s_d.rdData = 32'h0;
          end
        endcase
      end
    end
  end

  // Parameter clear has no path into the selection register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '{sel: SEL_RESET, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign rdData = s_q.rdData;
  assign resetAccepted = s_q.resetAccepted;
  assign outputShutoff = s_q.outputShutoff;
  assign thermalClear = s_q.thermalClear;
  assign panelLossFault = s_q.panelFault;
  assign decelStop = s_q.decelStop;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_initCode;
    $rose(resetn) |-> s_q.sel == 7'h0E;
  endproperty
  a_initCode: assert property (p_initCode) else $error("selection code not 14 after reset");

  property p_onlyTrip;
    (ce && extReq && !panelResetKey && dec.onlyOnTrip && !faultActive) |=> !resetAccepted;
  endproperty
  a_onlyTrip: assert property (p_onlyTrip) else $error("reset taken without a trip");

  property p_always;
    (ce && commResetCmd && !dec.onlyOnTrip && !blocked) |=> resetAccepted;
  endproperty
  a_always: assert property (p_always) else $error("communication reset refused");

  sequence s_runReset;
    ce && acceptNow && running;
  endsequence
  property p_coast;
    s_runReset |=> (outputShutoff && thermalClear);
  endproperty
  a_coast: assert property (p_coast) else $error("reset while running did not coast");

  property p_key;
    (ce && panelResetKey && !extReq && !faultActive) |=> !resetAccepted;
  endproperty
  a_key: assert property (p_key) else $error("panel reset key taken without fault");

  property p_stopMode;
    (ce && panelStopKey && !panelJog && opMode != MODE_PANEL && !dec.stopAll) |=> !decelStop;
  endproperty
  a_stopMode: assert property (p_stopMode) else $error("stop key acted outside panel mode");

  property p_write;
    (ce && selWrite && selOk) |=> s_q.sel == $past(bus.wrData[6:0]);
  endproperty
  a_write: assert property (p_write) else $error("legal selection write lost");

  property p_reject;
    (ce && selWrite && !selOk) |=> $stable(s_q.sel);
  endproperty
  a_reject: assert property (p_reject) else $error("illegal selection code stored");

  property p_serial;
    (serialOnConnector && !s_q.panelFault) |=> !s_q.panelFault;
  endproperty
  a_serial: assert property (p_serial) else $error("loss trip with serial connector");

  property p_clearKeeps;
    (paramClear && !(ce && selWrite)) |=> $stable(s_q.sel);
  endproperty
  a_clearKeeps: assert property (p_clearKeeps) else $error("parameter clear moved code");

  // ==========================================================
  // Reset gate checks
  property p_termAlways;
    (ce && extResetTerminal && !s_q.sel[0] && !blocked) |=> resetAccepted;
  endproperty
  a_termAlways: assert property (p_termAlways) else $error("terminal reset refused");

  property p_termTrip;
    (ce && extResetTerminal && tripActive && !blocked) |=> resetAccepted;
  endproperty
  a_termTrip: assert property (p_termTrip) else $error("terminal reset refused in trip");

  property p_keyTrip;
    (ce && panelResetKey && tripActive && !blocked) |=> resetAccepted;
  endproperty
  a_keyTrip: assert property (p_keyTrip) else $error("panel reset key refused in trip");

  property p_shutIdle;
    (ce && !running) |=> !outputShutoff;
  endproperty
  a_shutIdle: assert property (p_shutIdle) else $error("output shut off while stopped");

  property p_porClear;
    ($rose(resetn) && ce) |=> thermalClear;
  endproperty
  a_porClear: assert property (p_porClear) else $error("thermal sum kept over power-on");

  // ==========================================================
  // Reset limit checks
  // Only the high codes arm the limit, and a cooled motor always frees it
  property p_limitHold;
    (ce && extReq && s_q.sel >= 7'h64 && trips >= LIMIT_TRIPS && !thermalZero)
      |=> !resetAccepted;
  endproperty
  a_limitHold: assert property (p_limitHold) else $error("reset taken while limited");

  property p_limitOff;
    (s_q.sel < 7'h64) |-> !blocked;
  endproperty
  a_limitOff: assert property (p_limitOff) else $error("limit active on a low code");

  property p_limitFree;
    thermalZero |-> !blocked;
  endproperty
  a_limitFree: assert property (p_limitFree) else $error("limit held with zero sum");

  // ==========================================================
  // Panel-loss checks
  sequence s_lossTrip;
    ce && lost && dec.panelTrip && !serialOnConnector;
  endsequence
  property p_lossTrip;
    s_lossTrip |=> panelLossFault;
  endproperty
  a_lossTrip: assert property (p_lossTrip) else $error("panel loss did not trip");

  property p_keepRun;
    (!dec.panelTrip && !s_q.panelFault) |=> !panelLossFault;
  endproperty
  a_keepRun: assert property (p_keepRun) else $error("panel loss tripped a carry-on code");

  property p_armFirst;
    !armed |-> !s_q.panelFault;
  endproperty
  a_armFirst: assert property (p_armFirst) else $error("loss fault before panel was seen");

  // Jog keeps its own stop when codes 0, 1, 14 or 15 say carry on, but not under 100, 101, 114 or 115
  sequence s_jogLoss;
    ce && panelJog && lost && dec.continueCode && !serialOnConnector;
  endsequence
  property p_jogStop;
    s_jogLoss |=> decelStop;
  endproperty
  a_jogStop: assert property (p_jogStop) else $error("jog did not stop on panel loss");

  property p_serialStop;
    (ce && serialOnConnector && !panelStopKey) |=> !decelStop;
  endproperty
  a_serialStop: assert property (p_serialStop) else $error("stop raised on serial link");

  property p_stopAll;
    (ce && panelStopKey && dec.stopAll) |=> decelStop;
  endproperty
  a_stopAll: assert property (p_stopAll) else $error("stop key ignored in a wide code");

  property p_stopPanel;
    (ce && panelStopKey && opMode == MODE_PANEL) |=> decelStop;
  endproperty
  a_stopPanel: assert property (p_stopPanel) else $error("stop key ignored in panel mode");

  // ==========================================================
  // Register checks
  property p_highBits;
    (ce && selWrite && bus.wrData[31:7] != 25'h0) |=> $stable(s_q.sel);
  endproperty
  a_highBits: assert property (p_highBits) else $error("code with high bits stored");

  property p_gapCodes;
    (ce && selWrite && bus.wrData[6:0] > 7'h11 && bus.wrData[6:0] < 7'h64)
      |=> $stable(s_q.sel);
  endproperty
  a_gapCodes: assert property (p_gapCodes) else $error("gap code stored");

  // Read data stand for one cycle only, so a late look sees zero
  property p_rdStands;
    (ce && !bus.rd) |=> rdData == 32'h0;
  endproperty
  a_rdStands: assert property (p_rdStands) else $error("read data outlived its cycle");

endmodule : reset_panel_supervisor

`default_nettype wire

// ===== panel_model.sv
// Behavioural operator panel and reset sources facing the supervisor
`default_nettype none

module panel_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic attach,
  input wire logic [3:0] press,
  output logic panelPresent,
  output logic extResetTerminal,
  output logic commResetCmd,
  output logic panelResetKey,
  output logic panelStopKey
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Link and request pulses
  // Registered so every request leaves just after an edge, one cycle wide
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      panelPresent <= 1'b0;
      {panelStopKey, panelResetKey, commResetCmd, extResetTerminal} <= 4'h0;
    end else begin
      panelPresent <= attach;
      {panelStopKey, panelResetKey, commResetCmd, extResetTerminal} <= press;
    end
  end
endmodule : panel_model

`default_nettype wire

// ===== reset_panel_supervisor_tb_top.sv
// Self-checking bench for the reset gate and panel-loss supervisor
`default_nettype none

module reset_panel_supervisor_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import supervisor_pkg::*;

  // ==========================================================
  // Stimulus and model state
  // Short loss count keeps the run small; expectations follow it
  localparam int Loss = 20;
  logic clk = 1'b0, resetn = 1'b0, ce = 1'b1;
  busReq_t bus = '0;
  opMode_t opMode = MODE_PANEL;
  logic tripActive = 1'b0, thermOcTrip = 1'b0, thermalZero = 1'b1, running = 1'b0;
  logic serialOnConnector = 1'b0, panelJog = 1'b0, paramClear = 1'b0, attach = 1'b1;
  logic [3:0] press = 4'h0;
  logic panelPresent, extResetTerminal, commResetCmd, panelResetKey, panelStopKey;
  logic [31:0] rdData;
  logic resetAccepted, outputShutoff, thermalClear, panelLossFault, decelStop;
  logic e;
  int failures = 0, compares = 0;
  integer seed = 32'h86A0;
  int code, fault, m, i;
  int legal[16] = '{0, 1, 2, 3, 14, 15, 16, 17, 100, 101, 102, 103, 114, 115, 116, 117};
  logic [31:0] bad[6];

  panel_model partner (.clk(clk), .resetn(resetn), .attach(attach), .press(press),
    .panelPresent(panelPresent), .extResetTerminal(extResetTerminal),
    .commResetCmd(commResetCmd), .panelResetKey(panelResetKey),
    .panelStopKey(panelStopKey));

  reset_panel_supervisor #(.LossCycles(Loss), .HighCapacity(1'b1)) dut (.clk(clk),
    .resetn(resetn), .ce(ce), .bus(bus), .rdData(rdData), .tripActive(tripActive),
    .thermOcTrip(thermOcTrip), .thermalZero(thermalZero), .running(running),
    .opMode(opMode), .panelPresent(panelPresent), .serialOnConnector(serialOnConnector),
    .panelJog(panelJog), .extResetTerminal(extResetTerminal), .commResetCmd(commResetCmd),
    .panelResetKey(panelResetKey), .panelStopKey(panelStopKey), .paramClear(paramClear),
    .resetAccepted(resetAccepted), .outputShutoff(outputShutoff),
    .thermalClear(thermalClear), .panelLossFault(panelLossFault), .decelStop(decelStop));

  initial begin
    forever #12.5 clk = ~clk;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    bus <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wrData: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdData, exp);
  endtask : rd

  // Index 0 terminal, 1 link command, 2 panel reset key, 3 stop key
  task automatic push(input int k);
    @(posedge clk);
    press[k] <= 1'b1;
    @(posedge clk);
    press[k] <= 1'b0;
    cyc(1);
  endtask : push

  function automatic int base(input int c);
    return (c >= 100) ? c - 100 : c;
  endfunction : base

  task automatic loss(input int c, input logic ser, input logic jog);
    wr(SEL_OFFSET, 32'(c));
    @(posedge clk);
    serialOnConnector <= ser;
    panelJog <= jog;
    attach <= 1'b0;
    cyc(Loss);
    chk(panelLossFault, 1'b0);
    cyc(6);
    chk(panelLossFault, base(c) % 14 >= 2 && !ser);
    chk(decelStop, jog && (c == 0 || c == 1 || c == 14 || c == 15));
    @(posedge clk);
    attach <= 1'b1;
    serialOnConnector <= 1'b0;
    panelJog <= 1'b0;
    cyc(3);
    push(0);
    cyc(1);
    chk(panelLossFault, 1'b0);
  endtask : loss

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    cyc(1);
    chk(thermalClear, 1'b1);
    rd(SEL_OFFSET, 32'h0000000E);
    rd(STATUS_OFFSET, 32'h00000008);
    rd(4'hC, 32'h00000000);
    $display("Test reset values done");
    for (i = 0; i < 16; i++) begin
      code = legal[i];
      wr(SEL_OFFSET, 32'(code));
      rd(SEL_OFFSET, 32'(code));
      for (fault = 0; fault < 2; fault++) begin
        for (m = 0; m < 3; m++) begin
          @(posedge clk);
          tripActive <= fault[0];
          running <= 1'($random(seed));
          push(m);
          e = (m == 2) ? fault[0] : (base(code) % 2 == 0 || fault != 0);
          chk(resetAccepted, e);
          chk(thermalClear, e);
          chk(outputShutoff, e & running);
        end
      end
      for (m = 0; m < 3; m++) begin
        @(posedge clk);
        opMode <= opMode_t'(2'(m));
        push(3);
        chk(decelStop, m == 0 || base(code) >= 14);
      end
    end
    @(posedge clk);
    tripActive <= 1'b0;
    $display("Test code table done");
    bad = '{32'h4, 32'hD, 32'h12, 32'h63, 32'h76, 32'($random(seed)) | 32'h80};
    wr(SEL_OFFSET, 32'h0000000E);
    for (i = 0; i < 6; i++) begin
      wr(SEL_OFFSET, bad[i]);
      rd(SEL_OFFSET, 32'h0000000E);
    end
    @(posedge clk);
    paramClear <= 1'b1;
    @(posedge clk);
    paramClear <= 1'b0;
    rd(SEL_OFFSET, 32'h0000000E);
    $display("Test illegal writes done");
    loss(16, 1'b0, 1'b0);
    loss(14, 1'b0, 1'b1);
    loss(16, 1'b1, 1'b0);
    loss(2, 1'b0, 1'b1);
    for (m = 0; m < 2; m++) begin
      @(posedge clk);
      attach <= 1'b0;
      cyc(Loss - 3);
      @(posedge clk);
      attach <= 1'b1;
      cyc(3);
    end
    chk(panelLossFault, 1'b0);
    $display("Test panel loss done");
    wr(SEL_OFFSET, 32'(114));
    @(posedge clk);
    thermalZero <= 1'b0;
    tripActive <= 1'b1;
    repeat (2) begin
      @(posedge clk);
      thermOcTrip <= 1'b1;
      @(posedge clk);
      thermOcTrip <= 1'b0;
    end
    push(0);
    chk(resetAccepted, 1'b0);
    push(2);
    chk(resetAccepted, 1'b0);
    rd(STATUS_OFFSET, 32'h0000002D);
    wr(SEL_OFFSET, 32'(14));
    push(1);
    chk(resetAccepted, 1'b1);
    wr(SEL_OFFSET, 32'(114));
    push(0);
    chk(resetAccepted, 1'b0);
    @(posedge clk);
    thermalZero <= 1'b1;
    push(0);
    chk(resetAccepted, 1'b1);
    @(posedge clk);
    ce <= 1'b0;
    push(1);
    chk(resetAccepted, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    $display("Test reset limit done");
    @(posedge clk);
    tripActive <= 1'b0;
    attach <= 1'b0;
    resetn <= 1'b0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    cyc(1);
    chk(thermalClear, 1'b1);
    rd(SEL_OFFSET, 32'h0000000E);
    wr(SEL_OFFSET, 32'(16));
    cyc(Loss + 8);
    chk(panelLossFault, 1'b0);
    $display("Test absent at power-on done");
    conclude();
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    conclude();
  end
endmodule : reset_panel_supervisor_tb_top

`default_nettype wire
